/* rtl/bmr_regs.sv */
// register bank: status flags, balancing, system control and short-circuit protection
`timescale 1ns/1ps
`default_nettype none

module bmr_regs
	import bmr_pkg::*;
#(
	parameter int READING_LEN = READING_CYCLES
) (
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// register access from the serial transport
	input  wire bmr_req_type   req,
	output logic [7:0]         rdata_ff,
	// front-end events and pins
	input  wire bmr_event_type events,
	input  wire logic          alert_pin_in,
	input  wire logic          alert_drive_high,
	input  wire logic          load_sense_level,
	// controls out to the analog front end
	output logic [14:0]        cell_balance_enable,
	output logic               conv_enable,
	output logic               overvolt_prot_enable,
	output logic               temp_source_thermistor,
	output logic               shutdown_request,
	output logic               protection_delay_bypass,
	output logic               counter_running,
	output logic               discharge_gate_pin,
	output logic               charge_gate_pin,
	output logic               current_range_select,
	output logic [15:0]        sc_delay_us,
	output logic [15:0]        sc_threshold_mv
);

	initial begin
		if (READING_LEN < 2)
			$error("bmr_regs: READING_LEN must be at least 2");
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] alert_sync_ff;
	logic [2:0] load_sync_ff;
	logic       alert_level_ff;
	logic       load_level_ff;

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			alert_sync_ff <= 3'b000;
			load_sync_ff  <= 3'b000;
		end else begin
			alert_sync_ff <= {alert_sync_ff[1:0], alert_pin_in};
			load_sync_ff  <= {load_sync_ff[1:0], load_sense_level};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			alert_level_ff <= 1'b0;
			load_level_ff  <= 1'b0;
		end else begin
			if (alert_sync_ff[1] == alert_sync_ff[2])
				alert_level_ff <= alert_sync_ff[2];
			if (load_sync_ff[1] == load_sync_ff[2])
				load_level_ff <= load_sync_ff[2];
		end
	end

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	function automatic logic hit(input bmr_req_type r, input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	logic wr_status;
	logic wr_bal1;
	logic wr_bal2;
	logic wr_bal3;
	logic wr_ctrl1;
	logic wr_ctrl2;
	logic wr_prot;

	assign wr_status = hit(req, ADDR_FAULT_STATUS);
	assign wr_bal1   = hit(req, ADDR_BAL_1_5);
	assign wr_bal2   = hit(req, ADDR_BAL_6_10);
	assign wr_bal3   = hit(req, ADDR_BAL_11_15);
	assign wr_ctrl1  = hit(req, ADDR_SYS_CTRL_1);
	assign wr_ctrl2  = hit(req, ADDR_SYS_CTRL_2);
	assign wr_prot   = hit(req, ADDR_SC_PROTECT);

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	logic [7:0] status_ff;
	logic [7:0] nxt_status;
	logic [7:0] set_vec;
	logic       reading_done;
	logic       pullup_seen;

	// external pull-up counts only while we are not driving high
	assign pullup_seen = alert_level_ff && !alert_drive_high;

	always_comb begin
		set_vec = 8'h00;
		set_vec[ST_RESULT_FRESH] = reading_done;
		set_vec[ST_INTERNAL]     = events.internal_fault;
		set_vec[ST_ALERT_PULLUP] = pullup_seen;
		set_vec[ST_UNDERVOLT]    = events.undervolt;
		set_vec[ST_OVERVOLT]     = events.overvolt;
		set_vec[ST_SHORT]        = events.short_circuit;
		set_vec[ST_OVERCURRENT]  = events.overcurrent;
		nxt_status = status_ff;
		// ones clear, zeros keep; a same-cycle event wins
		if (wr_status)
			nxt_status = status_ff & ~req.wdata;
		nxt_status = (nxt_status | set_vec) & STATUS_MASK;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			status_ff <= RESET_VALUE;
		else
			status_ff <= nxt_status;
	end

	// ----------------------------------------------------------------
	// balancing and control registers
	// ----------------------------------------------------------------
	logic [7:0] bal1_ff;
	logic [7:0] bal2_ff;
	logic [7:0] bal3_ff;
	logic [7:0] ctrl1_ff;
	logic [7:0] ctrl2_ff;
	logic [7:0] prot_ff;
	logic       clear_single;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bal1_ff <= RESET_VALUE;
			bal2_ff <= RESET_VALUE;
			bal3_ff <= RESET_VALUE;
			prot_ff <= RESET_VALUE;
		end else begin
			if (wr_bal1)
				bal1_ff <= req.wdata & BAL_MASK;
			if (wr_bal2)
				bal2_ff <= req.wdata & BAL_MASK;
			if (wr_bal3)
				bal3_ff <= req.wdata & BAL_MASK;
			if (wr_prot)
				prot_ff <= req.wdata & PROT_MASK;
		end
	end

	// control one: bit 7 is live and never stored
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ctrl1_ff <= RESET_VALUE;
		else if (wr_ctrl1)
			ctrl1_ff <= req.wdata & CTRL1_MASK;
	end

	// control two; hardware clearing of the single bit beats a host write
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ctrl2_ff <= RESET_VALUE;
		else begin
			if (wr_ctrl2)
				ctrl2_ff <= req.wdata;
			if (clear_single)
				ctrl2_ff[C2_SINGLE] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// shutdown sequence
	// ----------------------------------------------------------------
	bmr_shut_type shut_ff;

	// any write that breaks 00 -> 01 -> 10 drops back to idle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			shut_ff <= SHS_IDLE;
		else if (wr_ctrl1) begin
			unique case (shut_ff)
			SHS_IDLE: begin
				if (ctrl1_ff[1:0] == SHUT_IDLE && req.wdata[1:0] == SHUT_STEP1)
					shut_ff <= SHS_ARMED;
			end
			SHS_ARMED: begin
				if (req.wdata[1:0] == SHUT_STEP2)
					shut_ff <= SHS_FIRED;
				else
					shut_ff <= SHS_IDLE;
			end
			SHS_FIRED: begin
				shut_ff <= SHS_FIRED;
			end
			default: begin
				shut_ff <= SHS_IDLE;
			end
			endcase
		end
	end

	assign shutdown_request = (shut_ff == SHS_FIRED);

	// ----------------------------------------------------------------
	// coulomb counter sequencing
	// ----------------------------------------------------------------
	bmr_cc_type  cc_ff;
	logic [31:0] cc_count_ff;
	logic        window_end;

	assign window_end   = (cc_count_ff == 32'(READING_LEN - 1));
	// continuous results come from the converter, single ones from our timer
	assign reading_done = (cc_ff == CC_CONT) ? events.result_done
		: (cc_ff == CC_SINGLE && window_end);
	assign clear_single = (cc_ff == CC_SINGLE) && window_end;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cc_ff       <= CC_OFF;
			cc_count_ff <= 32'h0000_0000;
		end else begin
			unique case (cc_ff)
			CC_OFF: begin
				cc_count_ff <= 32'h0000_0000;
				if (ctrl2_ff[C2_CONTINUOUS])
					cc_ff <= CC_CONT;
				else if (ctrl2_ff[C2_SINGLE])
					cc_ff <= CC_SINGLE;
			end
			CC_SINGLE: begin
				cc_count_ff <= cc_count_ff + 32'h0000_0001;
				if (ctrl2_ff[C2_CONTINUOUS])
					cc_ff <= CC_CONT;
				else if (window_end)
					cc_ff <= CC_OFF;
			end
			CC_CONT: begin
				cc_count_ff <= 32'h0000_0000;
				if (!ctrl2_ff[C2_CONTINUOUS])
					cc_ff <= CC_OFF;
			end
			default: begin
				cc_ff <= CC_OFF;
			end
			endcase
		end
	end

	assign counter_running = (cc_ff != CC_OFF);

	// ----------------------------------------------------------------
	// outputs to the front end
	// ----------------------------------------------------------------
	logic load_present;

	// reads zero whenever the charge driver is on
	assign load_present = load_level_ff && !ctrl2_ff[C2_CHARGE_GATE_ON];

	assign cell_balance_enable = {bal3_ff[4:0], bal2_ff[4:0], bal1_ff[4:0]};
	assign conv_enable             = ctrl1_ff[C1_CONV_EN];
	assign overvolt_prot_enable    = ctrl1_ff[C1_CONV_EN];
	assign temp_source_thermistor  = ctrl1_ff[C1_TEMP_SEL];
	assign protection_delay_bypass = ctrl2_ff[C2_DELAY_BYPASS];
	assign discharge_gate_pin      = ctrl2_ff[C2_DISCHARGE_GATE_ON];
	assign charge_gate_pin         = ctrl2_ff[C2_CHARGE_GATE_ON];
	assign current_range_select    = prot_ff[PR_RANGE];

	// protection settings decoded into physical units for the comparators
	always_comb begin
		sc_delay_us = 16'(SC_DELAY_US[prot_ff[4:3]]);
		if (prot_ff[PR_RANGE])
			sc_threshold_mv = 16'(SC_THR_HIGH_MV[prot_ff[2:0]]);
		else
			sc_threshold_mv = 16'(SC_THR_LOW_MV[prot_ff[2:0]]);
	end

	// ----------------------------------------------------------------
	// read mux, registered; unmapped offsets read zero
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			rdata_ff <= 8'h00;
		else if (req.rd) begin
			unique case (req.addr)
			ADDR_FAULT_STATUS: rdata_ff <= status_ff;
			ADDR_BAL_1_5:      rdata_ff <= bal1_ff;
			ADDR_BAL_6_10:     rdata_ff <= bal2_ff;
			ADDR_BAL_11_15:    rdata_ff <= bal3_ff;
			ADDR_SYS_CTRL_1:   rdata_ff <= {load_present, ctrl1_ff[6:0]};
			ADDR_SYS_CTRL_2:   rdata_ff <= ctrl2_ff;
			ADDR_SC_PROTECT:   rdata_ff <= prot_ff;
			default:           rdata_ff <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_clear_one_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_status && req.wdata[ST_SHORT] && !events.short_circuit
		|=> !status_ff[ST_SHORT])
		else $error("status bit not cleared by writing one");

	a_zero_keeps_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_status && !req.wdata[ST_SHORT] && status_ff[ST_SHORT]
		|=> status_ff[ST_SHORT])
		else $error("writing zero changed a status bit");

	a_fresh_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reading_done |=> status_ff[ST_RESULT_FRESH])
		else $error("fresh result flag not set");

	a_fault_latches: assert property (@(posedge clk_sys) disable iff (!rst_n)
		status_ff[ST_INTERNAL] && !wr_status |=> status_ff[ST_INTERNAL])
		else $error("internal fault flag dropped without clear");

	a_pullup_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!$past(status_ff[ST_ALERT_PULLUP]) && status_ff[ST_ALERT_PULLUP]
		|-> $past(!alert_drive_high))
		else $error("pull-up flag set while driving alert high");

	a_load_zero_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req.rd && req.addr == ADDR_SYS_CTRL_1 && ctrl2_ff[C2_CHARGE_GATE_ON]
		|=> !rdata_ff[C1_LOAD_PRESENT])
		else $error("load present read high while charge driver on");

	sequence s_step1;
		wr_ctrl1 && shut_ff == SHS_IDLE && ctrl1_ff[1:0] == SHUT_IDLE
			&& req.wdata[1:0] == SHUT_STEP1;
	endsequence

	// second step may come any number of cycles after the first
	sequence s_step2;
		wr_ctrl1 && shut_ff == SHS_ARMED && req.wdata[1:0] == SHUT_STEP2;
	endsequence

	a_shut_arms: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_step1 |=> shut_ff == SHS_ARMED)
		else $error("first shutdown write not accepted");

	a_shut_sequence: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_step2 |=> shutdown_request)
		else $error("valid shutdown sequence not accepted");

	a_shut_broken: assert property (@(posedge clk_sys) disable iff (!rst_n)
		shut_ff == SHS_ARMED && wr_ctrl1 && req.wdata[1:0] != SHUT_STEP2
		|=> !shutdown_request)
		else $error("broken shutdown sequence still fired");

	a_single_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clear_single |=> !ctrl2_ff[C2_SINGLE] && status_ff[ST_RESULT_FRESH]
			&& cc_ff != CC_SINGLE)
		else $error("single reading did not finish cleanly");

	a_cont_ignores: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrl2_ff[C2_CONTINUOUS] |=> cc_ff == CC_CONT)
		else $error("counter not in continuous mode while enabled");

	a_range_doubles: assert property (@(posedge clk_sys) disable iff (!rst_n)
		prot_ff[PR_RANGE] |-> sc_threshold_mv
			== 16'(SC_THR_HIGH_MV[prot_ff[2:0]]))
		else $error("range select not applied to threshold");

endmodule

`default_nettype wire

/* rtl/bmr_pkg.sv */
// package: register map, field positions and timing constants of the monitor registers
package bmr_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_FAULT_STATUS = 8'h00;
	localparam logic [7:0] ADDR_BAL_1_5      = 8'h01;
	localparam logic [7:0] ADDR_BAL_6_10     = 8'h02;
	localparam logic [7:0] ADDR_BAL_11_15    = 8'h03;
	localparam logic [7:0] ADDR_SYS_CTRL_1   = 8'h04;
	localparam logic [7:0] ADDR_SYS_CTRL_2   = 8'h05;
	localparam logic [7:0] ADDR_SC_PROTECT   = 8'h06;

	// ----------------------------------------------------------------
	// field positions and masks
	// ----------------------------------------------------------------
	localparam int ST_RESULT_FRESH = 7;
	localparam int ST_INTERNAL     = 5;
	localparam int ST_ALERT_PULLUP = 4;
	localparam int ST_UNDERVOLT    = 3;
	localparam int ST_OVERVOLT     = 2;
	localparam int ST_SHORT        = 1;
	localparam int ST_OVERCURRENT  = 0;
	localparam logic [7:0] STATUS_MASK  = 8'hBF;
	localparam logic [7:0] BAL_MASK     = 8'h1F;
	localparam int C1_LOAD_PRESENT = 7;
	localparam int C1_CONV_EN      = 4;
	localparam int C1_TEMP_SEL     = 3;
	localparam logic [7:0] CTRL1_MASK   = 8'h1F;
	localparam int C2_DELAY_BYPASS = 7;
	localparam int C2_CONTINUOUS   = 6;
	localparam int C2_SINGLE       = 5;
	localparam int C2_DISCHARGE_GATE_ON       = 1;
	localparam int C2_CHARGE_GATE_ON       = 0;
	localparam logic [7:0] PROT_MASK    = 8'hBF;
	localparam int PR_RANGE        = 7;
	localparam logic [7:0] RESET_VALUE  = 8'h00;

	// shutdown sequence codes in bits 1-0 (a, b)
	localparam logic [1:0] SHUT_IDLE  = 2'b00;
	localparam logic [1:0] SHUT_STEP1 = 2'b01;
	localparam logic [1:0] SHUT_STEP2 = 2'b10;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int  CLK_HZ           = 25_000_000;
	localparam int  READING_MS       = 250;
	localparam int  READING_CYCLES   = CLK_HZ / 1000 * READING_MS;
	localparam int  SC_DELAY_US [4]  = '{70, 100, 200, 400};
	localparam int  SC_THR_LOW_MV [8] = '{22, 33, 44, 56, 67, 78, 89, 100};
	localparam int  SC_THR_HIGH_MV [8] = '{44, 67, 89, 111, 133, 155, 178, 200};

	// register read and write request from the serial transport
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bmr_req_type;

	// raw fault and event inputs from the analog front end
	typedef struct packed {
		logic result_done;
		logic internal_fault;
		logic undervolt;
		logic overvolt;
		logic short_circuit;
		logic overcurrent;
	} bmr_event_type;

	typedef enum logic [1:0] {
		SHS_IDLE  = 2'b00,
		SHS_ARMED = 2'b01,
		SHS_FIRED = 2'b11
	} bmr_shut_type;

	typedef enum logic [1:0] {
		CC_OFF    = 2'b00,
		CC_SINGLE = 2'b01,
		CC_CONT   = 2'b11
	} bmr_cc_type;

endpackage

/* verif/bmr_host_model.sv */
// host model: issues single-byte register writes and reads to the bank
`timescale 1ns/1ps
`default_nettype none

module bmr_host_model
	import bmr_pkg::*;
(
	// clock
	input  wire logic        clk_sys,
	// register access
	output var bmr_req_type  req,
	input  wire logic [7:0]  rdata_ff
);
	// idle bus at time zero
	initial begin
		req <= '0;
	end

	// one write: held until the taking edge; released lines show inverse
	// values so a stale byte cannot pass for a live one.
	// callers may set reserved bits and start single readings only with
	// continuous mode off and the ready flag clear
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// one read: data is registered at the taking edge, sampled one edge on
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
		@(posedge clk_sys);
		d = rdata_ff;
	endtask
endmodule

`default_nettype wire

/* verif/bmr_regs_tb_top.sv */
// testbench: register bank checked through host model read/write calls
`timescale 1ns/1ps
`default_nettype none

module bmr_regs_tb_top
	import bmr_pkg::*;
;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int LEN = 20;  // short single reading keeps the run brief
	logic          clk_sys;
	logic          rst_n;
	bmr_req_type   req;
	logic [7:0]    rdata_ff;
	bmr_event_type events;
	logic          alert_pin_in;
	logic          alert_drive_high;
	logic          load_sense_level;
	logic [14:0]   cell_balance_enable;
	logic          conv_enable, overvolt_prot_enable, temp_source_thermistor;
	logic          shutdown_request, protection_delay_bypass, counter_running;
	logic          discharge_gate_pin, charge_gate_pin, current_range_select;
	logic [15:0]   sc_delay_us, sc_threshold_mv;
	int            miscompares = 0;
	int            tests_run = 0;

	bmr_regs #(.READING_LEN(LEN)) u_bmr_regs (
		.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata_ff(rdata_ff),
		.events(events), .alert_pin_in(alert_pin_in),
		.alert_drive_high(alert_drive_high),
		.load_sense_level(load_sense_level),
		.cell_balance_enable(cell_balance_enable), .conv_enable(conv_enable),
		.overvolt_prot_enable(overvolt_prot_enable),
		.temp_source_thermistor(temp_source_thermistor),
		.shutdown_request(shutdown_request),
		.protection_delay_bypass(protection_delay_bypass),
		.counter_running(counter_running),
		.discharge_gate_pin(discharge_gate_pin),
		.charge_gate_pin(charge_gate_pin),
		.current_range_select(current_range_select),
		.sc_delay_us(sc_delay_us), .sc_threshold_mv(sc_threshold_mv));

	bmr_host_model u_bmr_host_model (
		.clk_sys(clk_sys), .req(req), .rdata_ff(rdata_ff));

	// 25 MHz clock
	initial clk_sys = 1'b0;
	always #20 clk_sys = ~clk_sys;

	// ----------------------------------------------------------------
	// checking helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_bmr_host_model.rd(a, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_bmr_host_model.wr(a, d);
	endtask

	// one-cycle event pulse; the flag latches on the next edge
	task automatic pulse(input bmr_event_type e);
		@(posedge clk_sys);
		events <= e;
		@(posedge clk_sys);
		events <= '0;
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// watchdog: whole sequence needs far under 50000 cycles
	initial begin
		#2_000_000;
		miscompares++;
		$display("mismatch at %0t: watchdog expired", $time);
		stop_test;
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		logic [7:0] p;
		rst_n <= 1'b0;
		events <= '0;
		alert_pin_in <= 1'b0;
		alert_drive_high <= 1'b0;
		load_sense_level <= 1'b0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;

		// reset values, unmapped address reads zero
		for (int a = 0; a < 8; a++) rchk(8'(a), 8'h00);
		chk(sc_delay_us, 16'd70);
		chk(sc_threshold_mv, 16'd22);
		$display("test reset_values done");

		// fault flags latch; ones clear, zeros keep, writes never set
		wr(ADDR_FAULT_STATUS, 8'hFF);
		rchk(ADDR_FAULT_STATUS, 8'h00);
		pulse('{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1});
		repeat (4) @(posedge clk_sys);
		rchk(ADDR_FAULT_STATUS, 8'h2F);
		wr(ADDR_FAULT_STATUS, 8'h05);
		rchk(ADDR_FAULT_STATUS, 8'h2A);
		wr(ADDR_FAULT_STATUS, 8'hFF);
		rchk(ADDR_FAULT_STATUS, 8'h00);
		$display("test fault_flags done");

		// alert pull-up ignored while the device drives high itself
		alert_drive_high <= 1'b1;
		alert_pin_in <= 1'b1;
		repeat (8) @(posedge clk_sys);
		alert_pin_in <= 1'b0;
		repeat (8) @(posedge clk_sys);
		alert_drive_high <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rchk(ADDR_FAULT_STATUS, 8'h00);
		alert_pin_in <= 1'b1;
		repeat (8) @(posedge clk_sys);
		alert_pin_in <= 1'b0;
		rchk(ADDR_FAULT_STATUS, 8'h10);
		wr(ADDR_FAULT_STATUS, 8'h10);
		$display("test alert_pullup done");

		// balancing: bits 4-0 per cell, upper bits read zero
		wr(ADDR_BAL_1_5, 8'hE1);
		wr(ADDR_BAL_6_10, 8'hF2);
		wr(ADDR_BAL_11_15, 8'h04);
		rchk(ADDR_BAL_1_5, 8'h01);
		rchk(ADDR_BAL_6_10, 8'h12);
		rchk(ADDR_BAL_11_15, 8'h04);
		chk({1'b0, cell_balance_enable}, 16'h1241);
		$display("test balancing done");

		// control one: converter, temperature source, load sense
		load_sense_level <= 1'b1;
		wr(ADDR_SYS_CTRL_1, 8'hF8);
		repeat (8) @(posedge clk_sys);
		chk({13'h0, conv_enable, overvolt_prot_enable,
			temp_source_thermistor}, 16'h0007);
		rchk(ADDR_SYS_CTRL_1, 8'h98);
		wr(ADDR_SYS_CTRL_2, 8'h83);
		@(posedge clk_sys);
		chk({13'h0, protection_delay_bypass, discharge_gate_pin,
			charge_gate_pin}, 16'h0007);
		rchk(ADDR_SYS_CTRL_1, 8'h18);
		wr(ADDR_SYS_CTRL_2, 8'h02);
		load_sense_level <= 1'b0;
		wr(ADDR_SYS_CTRL_1, 8'h00);
		repeat (8) @(posedge clk_sys);
		rchk(ADDR_SYS_CTRL_1, 8'h00);
		chk({13'h0, conv_enable, overvolt_prot_enable,
			temp_source_thermistor}, 16'h0000);
		chk({13'h0, protection_delay_bypass, discharge_gate_pin,
			charge_gate_pin}, 16'h0002);
		$display("test control_one done");

		// single reading: runs, clears itself, sets the ready flag
		wr(ADDR_SYS_CTRL_2, 8'h20);
		repeat (2) @(posedge clk_sys);
		chk({15'h0, counter_running}, 16'h0001);
		n = 0;
		// one reading lasts exactly the programmed window length
		while (counter_running === 1'b1 && n < LEN + 20) begin
			@(posedge clk_sys);
			n++;
		end
		chk({15'h0, counter_running}, 16'h0000);
		chk(16'(n), 16'(LEN));
		rchk(ADDR_SYS_CTRL_2, 8'h00);
		rchk(ADDR_FAULT_STATUS, 8'h80);
		wr(ADDR_FAULT_STATUS, 8'h80);
		$display("test single_reading done");

		// continuous mode keeps the counter running; flag stays latched
		wr(ADDR_SYS_CTRL_2, 8'h40);
		pulse('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
		pulse('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
		repeat (LEN + 10) @(posedge clk_sys);
		chk({15'h0, counter_running}, 16'h0001);
		rchk(ADDR_FAULT_STATUS, 8'h80);
		wr(ADDR_SYS_CTRL_2, 8'h00);
		repeat (2) @(posedge clk_sys);
		chk({15'h0, counter_running}, 16'h0000);
		$display("test continuous done");

		// protection decode over every code in both ranges
		for (int i = 0; i < 64; i++) begin
			p = {i[5], 1'b1, 1'b0, i[4:0]};
			wr(ADDR_SC_PROTECT, p);
			@(posedge clk_sys);
			chk(sc_delay_us, 16'(SC_DELAY_US[i[4:3]]));
			chk(sc_threshold_mv, i[5] ? 16'(SC_THR_HIGH_MV[i[2:0]])
				: 16'(SC_THR_LOW_MV[i[2:0]]));
			chk({15'h0, current_range_select}, {15'h0, i[5]});
		end
		rchk(ADDR_SC_PROTECT, 8'h9F);
		$display("test protection done");

		// shutdown: broken sequence ignored, clean one accepted
		wr(ADDR_SYS_CTRL_1, 8'h01);
		wr(ADDR_SYS_CTRL_1, 8'h03);
		wr(ADDR_SYS_CTRL_1, 8'h02);
		repeat (2) @(posedge clk_sys);
		chk({15'h0, shutdown_request}, 16'h0000);
		wr(ADDR_SYS_CTRL_1, 8'h00);
		wr(ADDR_SYS_CTRL_1, 8'h01);
		wr(ADDR_BAL_1_5, 8'h00);
		wr(ADDR_SYS_CTRL_1, 8'h02);
		repeat (2) @(posedge clk_sys);
		chk({15'h0, shutdown_request}, 16'h0001);
		$display("test shutdown done");
		stop_test;
	end
endmodule

`default_nettype wire
